// ==== include/dpc_pkg.sv ====
package dpc_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [5:0] POWER_IDX = 6'h05;
    localparam logic [5:0] CHAN_IDX = 6'h06;
    localparam logic [5:0] IRQ_STAT_IDX = 6'h20;
    localparam logic [5:0] IRQ_MASK_IDX = 6'h21;

    // Values after reset
    localparam logic [15:0] POWER_RST = 16'hafc0;
    localparam logic [15:0] CHAN_RST = 16'h0000;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Writable bits, and reserved bits that read back their reset value
    localparam logic [15:0] POWER_WR_MASK = 16'hb513;
    localparam logic [15:0] POWER_RSVD_RD = 16'h0280;
    localparam logic [15:0] CHAN_WR_MASK = 16'hfe00;

    // Power register fields
    localparam int P_CONV_PRI = 15;
    localparam int P_RSVD_ZERO = 14;
    localparam int P_ST_OFF = 13;
    localparam int P_DRV_HI = 12;
    localparam int P_ST_DONE = 11;
    localparam int P_CONV_SEC = 10;
    localparam int P_VG_OFF = 8;
    localparam int P_CONV_DONE = 6;
    localparam int P_BIAS = 4;
    localparam int P_EFF = 1;
    localparam int P_DEEMPH = 0;

    // Channel control fields
    localparam int C_VOL_HI = 15;
    localparam int C_VOL_LO = 14;
    localparam int C_RATE = 13;
    localparam int C_XFER = 12;
    localparam int C_ROLE = 11;
    localparam int C_SWING_HI = 10;
    localparam int C_SWING_LO = 9;
    localparam int C_LSAT = 7;
    localparam int C_RSAT = 6;

    // Volume link codes
    localparam logic [1:0] VOL_LEFT_FROM_RIGHT = 2'h1;
    localparam logic [1:0] VOL_RIGHT_FROM_LEFT = 2'h2;

    // Interrupt status bits
    localparam int IRQ_W = 4;
    localparam int I_LSAT = 0;
    localparam int I_RSAT = 1;
    localparam int I_ST_DONE = 2;
    localparam int I_CONV_DONE = 3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic en;
        logic [5:0] idx;
        logic [15:0] data;
        logic [1:0] strb;
    } dpc_wr_cmd_t;

    typedef struct packed {
        logic en;
        logic [5:0] idx;
    } dpc_rd_cmd_t;

    // Shared by the read and the write decode
    function automatic logic idx_mapped(input logic [5:0] idx);
        return (idx == POWER_IDX) || (idx == CHAN_IDX) ||
               (idx == IRQ_STAT_IDX) || (idx == IRQ_MASK_IDX);
    endfunction

endpackage

// ==== verification/test_dac_power_and_control_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_dac_power_and_control_regs;
    typedef struct packed {logic c; logic [15:0] d; logic [1:0] s; logic [8:0] o;} dpc_row_t;
    logic clk, rstn, awv, wv, bready, arv, rready, st_done, cv_done, lsat, rsat;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, vol, swing;
    logic awr, wr, bv, arr, rv, cp, so, dh, cs, vg, bs, ef, de, lfr, rfl, rs_o, xf, ro, irq;
    logic [15:0] sv [2];
    logic [31:0] rd;
    logic [1:0] rsp;
    int num_errors = 0;
    int cmp_count = 0;
    // Power rows first, then channel rows; last channel row also hits the flag bits
    dpc_row_t rows [9] = '{
        '{1'b0, 16'hbfd3, 2'h3, 9'h0ff}, '{1'b0, 16'h0280, 2'h3, 9'h000},
        '{1'b0, 16'h9281, 2'h3, 9'h0a1}, '{1'b0, 16'h2792, 2'h3, 9'h05e},
        '{1'b0, 16'hff93, 2'h1, 9'h05f}, '{1'b1, 16'h7e00, 2'h3, 9'h0fe},
        '{1'b1, 16'h8200, 2'h3, 9'h105}, '{1'b1, 16'hc400, 2'h3, 9'h188},
        '{1'b1, 16'hfec0, 2'h3, 9'h1fc}};
    localparam logic [7:0] PW_A = {dpc_pkg::POWER_IDX, 2'b00};
    localparam logic [7:0] CH_A = {dpc_pkg::CHAN_IDX, 2'b00};
    localparam logic [7:0] ST_A = {dpc_pkg::IRQ_STAT_IDX, 2'b00};
    localparam logic [7:0] MK_A = {dpc_pkg::IRQ_MASK_IDX, 2'b00};
    wire logic [8:0] pw_o = {1'b0, cp, so, dh, cs, vg, bs, ef, de};
    wire logic [8:0] ch_o = {vol, rs_o, xf, ro, swing, lfr, rfl};

    dpc_regs dpc_regs_inst (.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rready), .SIDETONE_OFF_DONE(st_done), .CONVERTER_OFF_DONE(cv_done),
        .LEFT_SATURATION(lsat), .RIGHT_SATURATION(rsat), .CONVERTER_OFF_PRIMARY(cp),
        .SIDETONE_POWER_OFF(so), .DRIVER_HIGH_POWER_SEL(dh), .CONVERTER_OFF_SECONDARY(cs),
        .VIRTUAL_GROUND_AMP_OFF(vg), .BIAS_LEVEL_SELECT(bs), .EFFECTS_FILTER_ON(ef),
        .DEEMPH_FILTER_ON(de), .VOLUME_LINK_SELECT(vol), .LEFT_VOL_FROM_RIGHT(lfr),
        .RIGHT_VOL_FROM_LEFT(rfl), .REFERENCE_RATE_SELECT(rs_o), .TRANSFER_MODE_SELECT(xf),
        .INTERFACE_ROLE_SELECT(ro), .OUTPUT_SWING_SELECT(swing), .IRQ(irq));

    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A wait that runs out of cycles ends the run as a failure
    task automatic tmo();
        num_errors++;
        summarize();
    endtask

    // Address and data offered together, each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                             output logic [1:0] resp);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= {2'b00, s};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
            if (wv === 1'b1 && wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        if (n == 50) tmo();
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        if (n == 50) tmo();
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        sv[0] = dpc_pkg::POWER_RST;
        sv[1] = dpc_pkg::CHAN_RST;
    endtask

    // Both registers must show their reset contents, in bits and at the outputs
    task automatic chk_rst();
        axi_read(PW_A, rd, rsp);
        cmp(rd, {16'h0000, dpc_pkg::POWER_RST});
        cmp(pw_o, 9'h0d8);
        axi_read(CH_A, rd, rsp);
        cmp(rd, 32'h0000_0000);
        cmp(ch_o, 9'h000);
    endtask

    initial begin
        {awv, wv, bready, arv, rready, lsat, rsat} = '0;
        rstn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        st_done = 1'b1;
        cv_done = 1'b1;
        @(posedge clk);
        do_reset();
        chk_rst();
        // Ordinary cases; reserved bits are written with their reset value only
        foreach (rows[i]) begin
            sv[rows[i].c] = (sv[rows[i].c] & ~{{8{rows[i].s[1]}}, {8{rows[i].s[0]}}}) |
                (rows[i].d & {{8{rows[i].s[1]}}, {8{rows[i].s[0]}}});
            axi_write(rows[i].c ? CH_A : PW_A, rows[i].d, rows[i].s, rsp);
            cmp(rsp, dpc_pkg::RESP_OKAY);
            axi_read(rows[i].c ? CH_A : PW_A, rd, rsp);
            cmp(rd, rows[i].c ? sv[1] & dpc_pkg::CHAN_WR_MASK :
                (sv[0] & dpc_pkg::POWER_WR_MASK) | dpc_pkg::POWER_RSVD_RD | 16'h0840);
            if (rows[i].c)
                cmp(ch_o, rows[i].o);
            else
                cmp(pw_o, rows[i].o);
        end
        // Overflow on both channels: flags stick, first read returns them, then cleared
        @(posedge clk);
        lsat <= 1'b1;
        rsat <= 1'b1;
        @(posedge clk);
        lsat <= 1'b0;
        rsat <= 1'b0;
        axi_read(CH_A, rd, rsp);
        cmp(rd, 32'h0000_fec0);
        axi_read(CH_A, rd, rsp);
        cmp(rd, 32'h0000_fe00);
        // Interrupt: pending but masked, unmasked, then bit 0 cleared while bit 1 stays pending
        axi_read(ST_A, rd, rsp);
        cmp(rd, 32'h0000_0003);
        cmp(irq, 1'b0);
        axi_write(MK_A, 16'h0001, 2'h3, rsp);
        repeat (2) @(posedge clk);
        cmp(irq, 1'b1);
        axi_write(ST_A, 16'h0001, 2'h3, rsp);
        repeat (2) @(posedge clk);
        cmp(irq, 1'b0);
        axi_read(ST_A, rd, rsp);
        cmp(rd, 32'h0000_0002);
        // Power-down still in progress reads as zero in both done flags
        st_done <= 1'b0;
        cv_done <= 1'b0;
        repeat (2) @(posedge clk);
        axi_read(PW_A, rd, rsp);
        cmp(rd, {16'h0000, (sv[0] & dpc_pkg::POWER_WR_MASK) | dpc_pkg::POWER_RSVD_RD});
        // Unmapped place: error response, no data
        axi_write(8'h40, 16'hffff, 2'h3, rsp);
        cmp(rsp, dpc_pkg::RESP_SLVERR);
        axi_read(8'h40, rd, rsp);
        cmp({rd[15:0], rsp}, {16'h0000, dpc_pkg::RESP_SLVERR});
        // Completion returning raises both done events in status
        st_done <= 1'b1;
        cv_done <= 1'b1;
        repeat (2) @(posedge clk);
        axi_read(ST_A, rd, rsp);
        cmp(rd, 32'h0000_000e);
        // Second reset in mid-run
        @(posedge clk);
        do_reset();
        chk_rst();
        summarize();
    end
endmodule
`default_nettype wire

// ==== verilog/dpc_axil_slave.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpc_axil_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output dpc_pkg::dpc_wr_cmd_t wr_cmd,
    input wire logic wr_ok,
    output dpc_pkg::dpc_rd_cmd_t rd_cmd,
    input wire logic [15:0] rd_data,
    input wire logic rd_ok
);
    logic aw_held_r;
    logic w_held_r;
    logic [5:0] aw_idx_r;
    logic [15:0] w_data_r;
    logic [1:0] w_strb_r;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic bvalid_nxt;
    logic ar_take;
    logic rvalid_nxt;

    // Address and data are held apart so they may arrive in either order
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign wr_fire = aw_held_r && w_held_r && !bvalid;
    assign aw_held_nxt = aw_take || (aw_held_r && !wr_fire);
    assign w_held_nxt = w_take || (w_held_r && !wr_fire);
    assign bvalid_nxt = wr_fire || (bvalid && !bready);

    assign wr_cmd = '{en: wr_fire, idx: aw_idx_r, data: w_data_r, strb: w_strb_r};

    // Ready is registered from next state; no new write until the response drains
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= dpc_pkg::RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awready <= !aw_held_nxt && !bvalid_nxt;
            wready <= !w_held_nxt && !bvalid_nxt;
            bvalid <= bvalid_nxt;
            if (wr_fire) begin
                bresp <= wr_ok ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
            end
        end
    end

    // Payload capture; upper byte lanes carry nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_idx_r <= 6'h00;
            w_data_r <= 16'h0000;
            w_strb_r <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_idx_r <= awaddr[7:2];
            end
            if (w_take) begin
                w_data_r <= wdata[15:0];
                w_strb_r <= wstrb[1:0];
            end
        end
    end

    // Read is answered at the edge after the address is taken
    assign ar_take = arvalid && arready;
    assign rvalid_nxt = ar_take || (rvalid && !rready);
    assign rd_cmd = '{en: ar_take, idx: araddr[7:2]};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dpc_pkg::RESP_OKAY;
        end else begin
            arready <= !rvalid_nxt;
            rvalid <= rvalid_nxt;
            if (ar_take) begin
                rdata <= {16'h0000, rd_data};
                rresp <= rd_ok ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/dpc_regs.sv ====
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dpc_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SIDETONE_OFF_DONE,
    input wire logic CONVERTER_OFF_DONE,
    input wire logic LEFT_SATURATION,
    input wire logic RIGHT_SATURATION,
    output logic CONVERTER_OFF_PRIMARY,
    output logic SIDETONE_POWER_OFF,
    output logic DRIVER_HIGH_POWER_SEL,
    output logic CONVERTER_OFF_SECONDARY,
    output logic VIRTUAL_GROUND_AMP_OFF,
    output logic BIAS_LEVEL_SELECT,
    output logic EFFECTS_FILTER_ON,
    output logic DEEMPH_FILTER_ON,
    output logic [1:0] VOLUME_LINK_SELECT,
    output logic LEFT_VOL_FROM_RIGHT,
    output logic RIGHT_VOL_FROM_LEFT,
    output logic REFERENCE_RATE_SELECT,
    output logic TRANSFER_MODE_SELECT,
    output logic INTERFACE_ROLE_SELECT,
    output logic [1:0] OUTPUT_SWING_SELECT,
    output logic IRQ
);
    // Word index sits in address bits 7:2, so narrower buses cannot reach the map
    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W must lie between 8 and 32");
        end
    endgenerate

    dpc_pkg::dpc_wr_cmd_t wr_cmd;
    dpc_pkg::dpc_rd_cmd_t rd_cmd;
    logic [15:0] rd_val;
    logic wr_ok;
    logic rd_ok;
    logic [15:0] pwr_r;
    logic [15:0] pwr_nxt;
    logic [15:0] chan_r;
    logic [15:0] chan_nxt;
    logic st_done_r;
    logic conv_done_r;
    logic st_prev_r;
    logic conv_prev_r;
    logic lsat_r;
    logic rsat_r;
    logic chan_read;
    logic [dpc_pkg::IRQ_W-1:0] stat_r;
    logic [dpc_pkg::IRQ_W-1:0] stat_nxt;
    logic [dpc_pkg::IRQ_W-1:0] mask_r;
    logic [dpc_pkg::IRQ_W-1:0] events;
    logic [dpc_pkg::IRQ_W-1:0] w1c;
    logic rd_was_power_r;

    // Merge write data under byte strobes, keeping read-only and reserved bits out
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] res;
        res = old;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 8; i++) begin
                if (strb[b] && mask[8*b+i]) begin
                    res[8*b+i] = data[8*b+i];
                end
            end
        end
        return res;
    endfunction

    dpc_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_cmd(wr_cmd),
        .wr_ok(wr_ok),
        .rd_cmd(rd_cmd),
        .rd_data(rd_val),
        .rd_ok(rd_ok)
    );

    assign wr_ok = dpc_pkg::idx_mapped(wr_cmd.idx);
    assign rd_ok = dpc_pkg::idx_mapped(rd_cmd.idx);

    // Power register: only the writable mask is stored, flags and reserved are not
    always_comb begin
        pwr_nxt = pwr_r;
        if (wr_cmd.en && wr_cmd.idx == dpc_pkg::POWER_IDX) begin
            pwr_nxt = merge(pwr_r, wr_cmd.data, wr_cmd.strb, dpc_pkg::POWER_WR_MASK);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            pwr_r <= dpc_pkg::POWER_RST & dpc_pkg::POWER_WR_MASK;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Power controls leave straight from the stored bits
    assign CONVERTER_OFF_PRIMARY = pwr_r[dpc_pkg::P_CONV_PRI];
    assign SIDETONE_POWER_OFF = pwr_r[dpc_pkg::P_ST_OFF];
    assign DRIVER_HIGH_POWER_SEL = pwr_r[dpc_pkg::P_DRV_HI];
    assign CONVERTER_OFF_SECONDARY = pwr_r[dpc_pkg::P_CONV_SEC];
    assign VIRTUAL_GROUND_AMP_OFF = pwr_r[dpc_pkg::P_VG_OFF];
    assign BIAS_LEVEL_SELECT = pwr_r[dpc_pkg::P_BIAS];
    assign EFFECTS_FILTER_ON = pwr_r[dpc_pkg::P_EFF];
    assign DEEMPH_FILTER_ON = pwr_r[dpc_pkg::P_DEEMPH];

    // Channel control register; saturation flags live in their own flops
    always_comb begin
        chan_nxt = chan_r;
        if (wr_cmd.en && wr_cmd.idx == dpc_pkg::CHAN_IDX) begin
            chan_nxt = merge(chan_r, wr_cmd.data, wr_cmd.strb, dpc_pkg::CHAN_WR_MASK);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            chan_r <= dpc_pkg::CHAN_RST;
        end else begin
            chan_r <= chan_nxt;
        end
    end

    assign VOLUME_LINK_SELECT = chan_r[dpc_pkg::C_VOL_HI:dpc_pkg::C_VOL_LO];
    assign REFERENCE_RATE_SELECT = chan_r[dpc_pkg::C_RATE];
    assign TRANSFER_MODE_SELECT = chan_r[dpc_pkg::C_XFER];
    assign INTERFACE_ROLE_SELECT = chan_r[dpc_pkg::C_ROLE];
    assign OUTPUT_SWING_SELECT = chan_r[dpc_pkg::C_SWING_HI:dpc_pkg::C_SWING_LO];

    // Decoded volume link; codes 00 and 11 both keep channels independent
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            LEFT_VOL_FROM_RIGHT <= 1'b0;
            RIGHT_VOL_FROM_LEFT <= 1'b0;
        end else begin
            LEFT_VOL_FROM_RIGHT <= VOLUME_LINK_SELECT == dpc_pkg::VOL_LEFT_FROM_RIGHT;
            RIGHT_VOL_FROM_LEFT <= VOLUME_LINK_SELECT == dpc_pkg::VOL_RIGHT_FROM_LEFT;
        end
    end

    // Completion flags track the analog side; they read complete during reset
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            st_done_r <= 1'b1;
            conv_done_r <= 1'b1;
            st_prev_r <= 1'b1;
            conv_prev_r <= 1'b1;
        end else begin
            st_done_r <= SIDETONE_OFF_DONE;
            conv_done_r <= CONVERTER_OFF_DONE;
            st_prev_r <= st_done_r;
            conv_prev_r <= conv_done_r;
        end
    end

    // Overflow flags: a hit in the reading cycle survives the clear
    assign chan_read = rd_cmd.en && rd_cmd.idx == dpc_pkg::CHAN_IDX;

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            lsat_r <= 1'b0;
            rsat_r <= 1'b0;
        end else begin
            lsat_r <= LEFT_SATURATION || (lsat_r && !chan_read);
            rsat_r <= RIGHT_SATURATION || (rsat_r && !chan_read);
        end
    end

    // Interrupt events; completion counts on its rising edge only
    assign events[dpc_pkg::I_LSAT] = LEFT_SATURATION;
    assign events[dpc_pkg::I_RSAT] = RIGHT_SATURATION;
    assign events[dpc_pkg::I_ST_DONE] = st_done_r && !st_prev_r;
    assign events[dpc_pkg::I_CONV_DONE] = conv_done_r && !conv_prev_r;

    always_comb begin
        w1c = '0;
        if (wr_cmd.en && wr_cmd.idx == dpc_pkg::IRQ_STAT_IDX && wr_cmd.strb[0]) begin
            w1c = wr_cmd.data[dpc_pkg::IRQ_W-1:0];
        end
        stat_nxt = (stat_r & ~w1c) | events;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            stat_r <= '0;
            mask_r <= dpc_pkg::IRQ_MASK_RST;
            IRQ <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (wr_cmd.en && wr_cmd.idx == dpc_pkg::IRQ_MASK_IDX && wr_cmd.strb[0]) begin
                mask_r <= wr_cmd.data[dpc_pkg::IRQ_W-1:0];
            end
            IRQ <= |(stat_r & mask_r); // One cycle behind status, keeps output a flop
        end
    end

    // Read mux; reserved bits return constants, power bit 14 always zero
    always_comb begin
        rd_val = 16'h0000;
        unique case (rd_cmd.idx)
            dpc_pkg::POWER_IDX: begin
                rd_val = (pwr_r & dpc_pkg::POWER_WR_MASK) | dpc_pkg::POWER_RSVD_RD;
                rd_val[dpc_pkg::P_ST_DONE] = st_done_r;
                rd_val[dpc_pkg::P_CONV_DONE] = conv_done_r;
                rd_val[dpc_pkg::P_RSVD_ZERO] = 1'b0;
            end
            dpc_pkg::CHAN_IDX: begin
                rd_val = chan_r & dpc_pkg::CHAN_WR_MASK;
                rd_val[dpc_pkg::C_LSAT] = lsat_r;
                rd_val[dpc_pkg::C_RSAT] = rsat_r;
            end
            dpc_pkg::IRQ_STAT_IDX: rd_val = {12'h000, stat_r};
            dpc_pkg::IRQ_MASK_IDX: rd_val = {12'h000, mask_r};
            default: rd_val = 16'h0000;
        endcase
    end

    // Helper for checks: remembers whether the pending read hit the power register
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            rd_was_power_r <= 1'b0;
        end else if (rd_cmd.en) begin
            rd_was_power_r <= rd_cmd.idx == dpc_pkg::POWER_IDX;
        end
    end

    sequence s_pwr_hi_write;
        wr_cmd.en && wr_cmd.idx == dpc_pkg::POWER_IDX && wr_cmd.strb[1];
    endsequence

    sequence s_chan_hi_write;
        wr_cmd.en && wr_cmd.idx == dpc_pkg::CHAN_IDX && wr_cmd.strb[1];
    endsequence

    sequence s_pwr_read;
        rd_cmd.en && rd_cmd.idx == dpc_pkg::POWER_IDX;
    endsequence

    a_conv_off_write: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_pwr_hi_write |=> CONVERTER_OFF_PRIMARY == $past(wr_cmd.data[15]))
        else $error("converter power-down bit did not follow the write");

    a_sidetone_write: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_pwr_hi_write |=> SIDETONE_POWER_OFF == $past(wr_cmd.data[13]))
        else $error("sidetone power-down bit did not follow the write");

    a_power_reset_vals: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        $rose(RSTN) |-> !DRIVER_HIGH_POWER_SEL && CONVERTER_OFF_PRIMARY &&
                         CONVERTER_OFF_SECONDARY && VIRTUAL_GROUND_AMP_OFF && !IRQ)
        else $error("power controls wrong after reset");

    a_st_flag_read: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_pwr_read ##1 S_AXI_RVALID |-> S_AXI_RDATA[11] == $past(st_done_r))
        else $error("sidetone completion flag misread");

    a_conv_flag_read: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_pwr_read ##1 S_AXI_RVALID |-> S_AXI_RDATA[6] == $past(CONVERTER_OFF_DONE, 2))
        else $error("converter completion flag misread");

    a_rsvd_zero: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        S_AXI_RVALID && rd_was_power_r |-> !S_AXI_RDATA[14] && S_AXI_RDATA[9])
        else $error("reserved power bits read wrong");

    // Writes are spaced by the bus response, so no second write lands inside the window
    a_vol_link: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        s_chan_hi_write |-> ##2
            (LEFT_VOL_FROM_RIGHT == ($past(wr_cmd.data[15:14], 2) == dpc_pkg::VOL_LEFT_FROM_RIGHT)) &&
            (RIGHT_VOL_FROM_LEFT == ($past(wr_cmd.data[15:14], 2) == dpc_pkg::VOL_RIGHT_FROM_LEFT)))
        else $error("volume link decode wrong");

    a_sat_set: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        LEFT_SATURATION |=> lsat_r)
        else $error("left saturation flag not set");

    a_sat_hold: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        rsat_r && !chan_read |=> rsat_r)
        else $error("right saturation flag lost without a read");

    a_sat_clear: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        lsat_r && chan_read && !LEFT_SATURATION |=> !lsat_r ##0 S_AXI_RDATA[7])
        else $error("left saturation flag not cleared by read");

    a_flag_wr_ignored: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        wr_cmd.en && !chan_read && !RIGHT_SATURATION |=> rsat_r == $past(rsat_r))
        else $error("write disturbed a read-only flag");

    a_irq_level: assert property (
        @(posedge CORE_CLK) disable iff (!RSTN)
        |(stat_r & mask_r) |=> IRQ)
        else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire
